// >>> verilog/ppl_lock.sv
// parameter password lock: AHB-Lite register slave, lock state, access gate
// assumes one AHB-Lite master, word transfers only; all inputs on core_clk
module ppl_lock
  import ppl_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire ppl_src_e bus_src,
  input wire logic group_read_select,
  input wire logic drive_run,
  input wire ppl_acc_s acc_req,
  output logic acc_grant,
  output logic locked_indication,
  output logic pw_error,
  output logic param_clear,
  output logic param_clear_all,
  output logic copy_ok,
  output logic irq
);

  // ==========================================================
  // bus phase tracking
  logic ap_take;
  logic dp_vld_r;
  logic dp_wr_r;
  logic rd_pend_r;
  logic [4:0] dp_addr_r;
  ppl_src_e dp_src_r;
  logic [31:0] hrdata_r;

  assign ap_take = hsel && hready && htrans[1];

  // reads take one wait state so they see the previous write
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dp_vld_r <= 1'b0;
      dp_wr_r <= 1'b0;
      rd_pend_r <= 1'b0;
      dp_addr_r <= 5'h00;
      dp_src_r <= SRC_PANEL;
    end else begin
      if (hready) begin
        dp_vld_r <= ap_take;
        dp_wr_r <= ap_take && hwrite;
        rd_pend_r <= ap_take && !hwrite;
        if (ap_take) begin
          dp_addr_r <= haddr[4:0];
          dp_src_r <= bus_src;
        end
      end else begin
        rd_pend_r <= 1'b0;
      end
    end
  end

  assign hreadyout = !rd_pend_r;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;

  // ==========================================================
  // write decode
  logic wr_go;
  logic w_lvl;
  logic w_pwd;
  logic w_cmd;
  logic w_mask;
  logic grp_blk;
  logic [13:0] wval;

  assign wr_go = dp_vld_r && dp_wr_r;
  assign wval = hwdata[13:0];
  // panel reads of level and entry, and panel level writes, follow the group read selection
  assign grp_blk = group_read_select && (dp_src_r == SRC_PANEL);
  assign w_lvl = wr_go && dp_addr_r == OFF_LEVEL && !grp_blk;
  assign w_pwd = wr_go && dp_addr_r == OFF_PWD;
  assign w_cmd = wr_go && dp_addr_r == OFF_CMD;
  assign w_mask = wr_go && dp_addr_r == OFF_MASK;

  // ==========================================================
  // lock state
  ppl_lock_e st_r;
  logic [13:0] level_r;
  logic [13:0] pw_r;
  logic [2:0] fail_r;
  logic locked;
  logic limited;
  logic prot_on;
  logic pw_ok;
  logic lvl_ok;
  logic all_go;
  logic clr_go;
  logic cpy_go;
  logic pw_set_go;
  logic entry_go;
  logic match;

  assign limited = lvl_limited(level_r);
  // locked and locked-up both keep the parameters shut
  assign locked = (st_r == LK_LOCKED) || (st_r == LK_LOCKUP);
  // no protection at all while the level reads 9999
  assign prot_on = (level_r != LVL_NONE) && locked;
  assign pw_ok = wval >= PW_MIN && wval <= PW_MAX;
  // level may not change under a lock
  assign lvl_ok = w_lvl && lvl_valid(wval) && !locked;
  // full clear is blocked by a running drive
  assign all_go = w_cmd && hwdata[CMD_ALL] && !drive_run;
  // plain clear under lock only from the option
  assign clr_go = w_cmd && hwdata[CMD_CLR] && !hwdata[CMD_ALL]
    && (!prot_on || dp_src_r == SRC_OPTION);
  // copy is shut while locked
  assign cpy_go = w_cmd && hwdata[CMD_CPY] && !prot_on;
  // a password is taken only when the level is not 9999
  assign pw_set_go = w_pwd && pw_ok && level_r != LVL_NONE
    && (st_r == LK_OPEN || st_r == LK_UNLOCKED);
  assign entry_go = w_pwd && pw_ok && locked;
  assign match = wval == pw_r;

  // restriction level register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      level_r <= LEVEL_RST;
    end else if (all_go) begin
      level_r <= LEVEL_RST;
    end else if (lvl_ok) begin
      level_r <= wval;
    end
  end

  // password store and lock state machine
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= LK_OPEN;
      pw_r <= LVL_NONE;
      fail_r <= 3'h0;
    end else if (all_go) begin
      // full clear wipes even a locked-up password
      st_r <= LK_OPEN;
      pw_r <= LVL_NONE;
      fail_r <= 3'h0;
    end else if (clr_go && (prot_on || st_r == LK_UNLOCKED)) begin
      st_r <= LK_OPEN;
      pw_r <= LVL_NONE;
      fail_r <= 3'h0;
    end else begin
      case (st_r)
        LK_OPEN, LK_UNLOCKED: begin
          if (pw_set_go) begin
            pw_r <= wval;
            st_r <= LK_LOCKED;
            fail_r <= 3'h0;
          end
        end
        LK_LOCKED: begin
          if (entry_go && match) begin
            st_r <= LK_UNLOCKED;
          end else if (entry_go && limited) begin
            fail_r <= fail_r + 3'h1;
            if (fail_r == FAIL_MAX - 3'h1) begin
              st_r <= LK_LOCKUP;
            end
          end
        end
        LK_LOCKUP: begin
          // entries are taken, none changes the state; a wrong one still flags pw_error
          st_r <= LK_LOCKUP;
        end
        default: st_r <= LK_OPEN;
      endcase
    end
  end

  // ==========================================================
  // parameter access gate
  logic acc_ok;

  ppl_acc_check u_chk (
    .level(level_r),
    .active(prot_on),
    .req(acc_req),
    .grant(acc_ok)
  );

  // device updates pass even under lock
  assign acc_grant = acc_req.vld && (acc_ok || acc_req.internal);

  // ==========================================================
  // pulse outputs
  logic mism;
  logic acc_deny;
  logic refused;

  assign mism = entry_go && !match;
  assign acc_deny = acc_req.vld && !acc_grant;
  assign refused = (w_pwd && !pw_set_go && !entry_go)
    || (w_lvl && !lvl_ok) || (w_cmd && !all_go && !clr_go && !cpy_go);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      locked_indication <= 1'b0;
      pw_error <= 1'b0;
      param_clear <= 1'b0;
      param_clear_all <= 1'b0;
      copy_ok <= 1'b0;
    end else begin
      locked_indication <= acc_deny;
      pw_error <= mism;
      param_clear <= clr_go;
      param_clear_all <= all_go; // restores every parameter
      copy_ok <= cpy_go;
    end
  end

  // ==========================================================
  // sticky events, mask, interrupt
  logic [EV_N-1:0] ev;
  logic [EV_N-1:0] stat_r;
  logic [EV_N-1:0] mask_r;
  logic rd_stat;

  always_comb begin
    ev = '0;
    ev[EV_UNLOCK] = entry_go && match && st_r == LK_LOCKED;
    ev[EV_MISMATCH] = mism;
    ev[EV_LOCKUP] = entry_go && !match && limited && st_r == LK_LOCKED
      && fail_r == FAIL_MAX - 3'h1;
    ev[EV_LOCKED_ACC] = acc_deny;
    ev[EV_REFUSED] = refused;
    ev[EV_CLEARED] = all_go || clr_go;
  end

  assign rd_stat = rd_pend_r && dp_addr_r == OFF_STAT;

  // a read clears, but an event in the same cycle stays set
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_r <= '0;
    end else begin
      stat_r <= (rd_stat ? '0 : stat_r) | ev;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_r <= MASK_RST;
    end else if (w_mask) begin
      mask_r <= hwdata[EV_N-1:0];
    end
  end

  assign irq = |(stat_r & mask_r);

  // ==========================================================
  // read mux, captured at the end of the wait state
  logic [31:0] rmux;

  always_comb begin
    rmux = 32'h0000_0000;
    case (dp_addr_r)
      OFF_LEVEL: rmux = grp_blk ? 32'h0 : {18'h0, level_r};
      OFF_PWD: begin
        if (grp_blk) begin
          rmux = 32'h0;
        end else if (st_r == LK_OPEN) begin
          rmux = {18'h0, LVL_NONE};
        end else begin
          // never the password itself count only when limited
          rmux = limited ? {29'h0, fail_r} : 32'h0;
        end
      end
      OFF_STAT: rmux = {26'h0, stat_r};
      OFF_MASK: rmux = {26'h0, mask_r};
      OFF_STATE: rmux = {27'h0, fail_r, st_r};
      default: rmux = 32'h0;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata_r <= 32'h0000_0000;
    end else if (rd_pend_r) begin
      hrdata_r <= rmux;
    end
  end

  logic [EV_N-1:0] ev_q; // event word one cycle late, for the checks below
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ev_q <= '0;
    end else begin
      ev_q <= ev;
    end
  end

  // ==========================================================
  // checks
  AST_NO_PROT: assert property (@(posedge core_clk) disable iff (!rst_n)
    level_r == LVL_NONE && acc_req.vld |-> acc_grant)
    else $error("access refused without protection");

  AST_FAIL_CAP: assert property (@(posedge core_clk) disable iff (!rst_n)
    fail_r <= FAIL_MAX && (st_r == LK_LOCKUP) == (fail_r == FAIL_MAX))
    else $error("failure count out of step with lockup");

  AST_LOCKUP_STAYS: assert property (@(posedge core_clk) disable iff (!rst_n)
    st_r == LK_LOCKUP && !all_go && !(clr_go && prot_on) |=> st_r == LK_LOCKUP)
    else $error("lockup left without a clear");

  AST_PW_REFUSE: assert property (@(posedge core_clk) disable iff (!rst_n)
    w_pwd && level_r == LVL_NONE && !all_go |=> $stable(pw_r) && ev_q[EV_REFUSED])
    else $error("password taken at level 9999");

  AST_SET_LOCKS: assert property (@(posedge core_clk) disable iff (!rst_n)
    pw_set_go && !all_go && !clr_go |=> st_r == LK_LOCKED && pw_r == $past(wval))
    else $error("password set did not lock");

  AST_PWD_READ: assert property (@(posedge core_clk) disable iff (!rst_n)
    rd_pend_r && dp_addr_r == OFF_PWD && st_r != LK_OPEN |=> hrdata_r <= 32'h5)
    else $error("entry read returned more than a count");

  AST_LOCKED_INDICATION: assert property (@(posedge core_clk) disable iff (!rst_n)
    acc_req.vld && prot_on && !acc_grant |=> locked_indication ##1 !locked_indication
      or locked_indication)
    else $error("no locked indication on refused access");

  AST_INTERNAL: assert property (@(posedge core_clk) disable iff (!rst_n)
    acc_req.vld && acc_req.internal |-> acc_grant)
    else $error("internal update blocked");

  AST_MISMATCH: assert property (@(posedge core_clk) disable iff (!rst_n)
    entry_go && !match && !all_go && !clr_go |=> pw_error && st_r != LK_UNLOCKED)
    else $error("wrong password not flagged");

  AST_ALLCLR: assert property (@(posedge core_clk) disable iff (!rst_n)
    all_go |=> st_r == LK_OPEN && level_r == LVL_NONE && param_clear_all)
    else $error("full clear incomplete");

  AST_RUN_REFUSE: assert property (@(posedge core_clk) disable iff (!rst_n)
    drive_run |=> !param_clear_all)
    else $error("full clear while running");

  AST_CLR_SRC: assert property (@(posedge core_clk) disable iff (!rst_n)
    w_cmd && prot_on && dp_src_r != SRC_OPTION && !hwdata[CMD_ALL] |=> !param_clear)
    else $error("plain clear taken from wrong source");

  AST_COPY: assert property (@(posedge core_clk) disable iff (!rst_n)
    w_cmd && prot_on |=> !copy_ok)
    else $error("copy taken while locked");

  AST_ENTRY_UP: assert property (@(posedge core_clk) disable iff (!rst_n)
    entry_go && st_r == LK_LOCKUP && !all_go |=> st_r == LK_LOCKUP && fail_r == FAIL_MAX)
    else $error("entry changed a locked-up password");

  AST_NET_READ: assert property (@(posedge core_clk) disable iff (!rst_n)
    rd_pend_r && dp_addr_r == OFF_LEVEL && dp_src_r != SRC_PANEL
      |=> hrdata_r == {18'h0, $past(level_r)})
    else $error("network read of level blocked");

  AST_LVL_LOCK: assert property (@(posedge core_clk) disable iff (!rst_n)
    w_lvl && locked && !all_go |=> $stable(level_r))
    else $error("level changed under lock");

  COV_UNLOCK: cover property (@(posedge core_clk) disable iff (!rst_n) ev[EV_UNLOCK]);
  COV_LOCKUP: cover property (@(posedge core_clk) disable iff (!rst_n) ev[EV_LOCKUP]);
  COV_ALLCLR: cover property (@(posedge core_clk) disable iff (!rst_n)
    all_go && st_r == LK_LOCKUP);
  COV_DENY: cover property (@(posedge core_clk) disable iff (!rst_n) acc_deny);

endmodule

// >>> verilog/ppl_pkg.sv
// constants, types and helpers of the parameter password lock
// assumes one core clock; levels and passwords are decimal values in 14 bits
// Contract
// - Protection is active only while the restriction level differs from 9999.
// - Levels 100 to 106 and 199 allow five failures and read back 0 to 5; others read 0.
// - Five failures at a limited level lock the password up until a full clear or a plain clear from the option.
// - A password of 1000 to 9998 is written to the entry; refused while the level is 9999.
// - A set password locks the parameters at the chosen level until the right one is given.
// - Once a password is set, the entry reads back only a value of 0 to 5.
// - A refused parameter access while locked raises the locked indication.
// - Internal parameter updates always go through, locked or not.
// - The right password unlocks; a wrong one flags an error and keeps the lock.
// - A full clear erases any password, locked-up too, and restores all parameters.
// - A full clear is refused while the drive output runs.
// - While locked, a plain clear is taken only from the option; full clear from any source.
// - While locked, parameter copy requests are refused.
// - When locked up, entries are taken but none unlocks or resets the lock.
// - Network sources may read level and entry whatever the group read selection.
// - The level sets read and write rights per panel, serial and option source.
package ppl_pkg;

  // ==========================================================
  // register map, byte addresses
  localparam logic [4:0] OFF_LEVEL = 5'h00;
  localparam logic [4:0] OFF_PWD = 5'h04;
  localparam logic [4:0] OFF_CMD = 5'h08;
  localparam logic [4:0] OFF_STAT = 5'h0c;
  localparam logic [4:0] OFF_MASK = 5'h10;
  localparam logic [4:0] OFF_STATE = 5'h14;

  // ==========================================================
  // values
  localparam logic [13:0] LVL_NONE = 14'h270f; // 9999
  localparam logic [13:0] LVL_GRP = 14'h0063; // 99
  localparam logic [13:0] LVL_LIM = 14'h0064; // 100
  localparam logic [13:0] LVL_GRP_LIM = 14'h00c7; // 199
  localparam logic [13:0] LVL_MAX_PLAIN = 14'h0006;
  localparam logic [13:0] PW_MIN = 14'h03e8; // 1000
  localparam logic [13:0] PW_MAX = 14'h270e; // 9998
  localparam logic [2:0] FAIL_MAX = 3'h5;
  localparam logic [13:0] LEVEL_RST = LVL_NONE;
  localparam logic [5:0] MASK_RST = 6'h00;

  // command register bit positions
  localparam int CMD_CLR = 0;
  localparam int CMD_ALL = 1;
  localparam int CMD_CPY = 2;

  // event bit positions
  localparam int EV_UNLOCK = 0;
  localparam int EV_MISMATCH = 1;
  localparam int EV_LOCKUP = 2;
  localparam int EV_LOCKED_ACC = 3;
  localparam int EV_REFUSED = 4;
  localparam int EV_CLEARED = 5;
  localparam int EV_N = 6;

  // ==========================================================
  // types
  typedef enum logic [1:0] {SRC_PANEL, SRC_SERIAL, SRC_OPTION} ppl_src_e;
  typedef enum logic [1:0] {LK_OPEN, LK_LOCKED, LK_UNLOCKED, LK_LOCKUP} ppl_lock_e;

  typedef struct packed {
    logic vld;
    logic wr;
    logic internal; // update made by the device itself
    logic in_group; // parameter registered in the user group
    ppl_src_e src;
  } ppl_acc_s;

  // ==========================================================
  // helpers
  function automatic logic lvl_limited(input logic [13:0] l);
    return (l >= LVL_LIM && l <= LVL_LIM + LVL_MAX_PLAIN) || l == LVL_GRP_LIM;
  endfunction

  function automatic logic lvl_valid(input logic [13:0] l);
    return l <= LVL_MAX_PLAIN || l == LVL_GRP || lvl_limited(l) || l == LVL_NONE;
  endfunction

endpackage

// >>> verilog/ppl_acc_check.sv
// per-source read and write rights for one parameter access
// assumes level holds a valid setting; purely combinational
module ppl_acc_check
  import ppl_pkg::*;
(
  input wire logic [13:0] level,
  input wire logic active,
  input wire ppl_acc_s req,
  output logic grant
);

  // rights per level 0..6 as {panel r,w, serial r,w, option r,w}
  function automatic logic [5:0] rights(input logic [2:0] b);
    case (b)
      3'h1: return 6'h2a;
      3'h2: return 6'h2f;
      3'h3: return 6'h3a;
      3'h4: return 6'h02;
      3'h5: return 6'h0f;
      3'h6: return 6'h32;
      default: return 6'h00;
    endcase
  endfunction

  logic [13:0] base;
  logic [2:0] idx;
  logic [5:0] r;
  logic grp_mode;

  // fold limited levels onto the plain ones; group levels use level 4
  always_comb begin
    base = (level >= LVL_LIM) ? level - LVL_LIM : level;
    grp_mode = (level == LVL_GRP) || (level == LVL_GRP_LIM);
    idx = grp_mode ? 3'h4 : base[2:0];
    r = rights(idx);
  end

  // pick the bit of the requesting source
  always_comb begin
    grant = 1'b1;
    if (req.internal) begin
      grant = 1'b1;
    end else if (active && !(grp_mode && req.in_group)) begin
      case (req.src)
        SRC_PANEL: grant = req.wr ? r[4] : r[5];
        SRC_SERIAL: grant = req.wr ? r[2] : r[3];
        SRC_OPTION: grant = req.wr ? r[0] : r[1];
        default: grant = 1'b0;
      endcase
    end
  end

endmodule

// >>> tb/ppl_host_model.sv
// ahb-lite master standing in for panel, serial host or option
// assumes hready is the slave's own hreadyout; one transfer per go pulse
module ppl_host_model (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic go,
  input wire logic [4:0] addr,
  input wire logic wr,
  input wire logic [31:0] wdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  output logic done,
  output logic [31:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] ph_r;
  assign hsize = 3'h2; // whole words only
  // ==========================================================
  // address phase held until hready, then data phase until hready
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ph_r <= 2'h0;
      hsel <= 1'b0;
      htrans <= 2'h0;
      haddr <= 32'h0;
      hwrite <= 1'b0;
      hwdata <= 32'h0;
      done <= 1'b0;
      rdata <= 32'h0;
    end else begin
      done <= 1'b0;
      case (ph_r)
        2'h0: begin
          hwdata <= ~hwdata; // released lines toggle, so the last word shows only every other cycle
          if (go) begin
            hsel <= 1'b1;
            htrans <= 2'h2;
            haddr <= {27'h0, addr};
            hwrite <= wr;
            ph_r <= 2'h1;
          end
        end
        2'h1: if (hready) begin
          htrans <= 2'h0;
          hwdata <= hwrite ? wdata : ~hwdata;
          ph_r <= 2'h2;
        end
        default: if (hready) begin
          rdata <= hrdata;
          done <= 1'b1;
          hsel <= 1'b0;
          ph_r <= 2'h0;
        end
      endcase
    end
  end
endmodule

// >>> tb/tb_ppl_lock.sv
// self-checking bench of the parameter password lock
// assumes the design's own assertions; reads are checked from a queue
module tb_ppl_lock
  import ppl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, rst_n, go, m_wr, m_done, hsel, hwrite, hrdy, seen_clr;
  logic grs, drive_run, acc_grant, lk_ind, pw_error, p_clr, p_all, copy_ok, irq, hresp;
  logic [4:0] m_addr, seen;
  logic [31:0] m_wd, m_rd, haddr, hwdata, hrdata, r;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [36:0] q[$];
  logic [36:0] mon_e;
  ppl_src_e bus_src;
  ppl_acc_s acc_req;
  int err_count = 0, n_checks = 0, i, seed = 32'he6aa;
  // ==========================================================
  // clock, the slave's hreadyout is the bus hready
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  ppl_lock i_dut (.core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hrdy),
    .hreadyout(hrdy), .hresp(hresp), .hrdata(hrdata), .bus_src(bus_src),
    .group_read_select(grs), .drive_run(drive_run), .acc_req(acc_req),
    .acc_grant(acc_grant), .locked_indication(lk_ind), .pw_error(pw_error),
    .param_clear(p_clr), .param_clear_all(p_all), .copy_ok(copy_ok), .irq(irq));
  ppl_host_model i_host (.core_clk(core_clk), .rst_n(rst_n), .go(go), .addr(m_addr),
    .wr(m_wr), .wdata(m_wd), .hready(hrdy), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .done(m_done),
    .rdata(m_rd));
  // ==========================================================
  // sticky capture of the one-cycle pulses since the last request
  always @(posedge core_clk) begin
    if (seen_clr) seen <= 5'h0;
    else seen <= seen | {copy_ok, p_all, p_clr, pw_error, lk_ind};
  end
  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // one bus transfer; a read notes its expected word first
  task automatic bus(input logic [4:0] a, input logic w, input logic [31:0] d,
    input ppl_src_e s);
    int k;
    if (!w) q.push_back({a, d});
    @(posedge core_clk);
    go <= 1'b1;
    seen_clr <= 1'b1;
    m_addr <= a;
    m_wr <= w;
    m_wd <= d;
    bus_src <= s;
    @(posedge core_clk);
    go <= 1'b0;
    seen_clr <= 1'b0;
    for (k = 0; k < 20 && m_done !== 1'b1; k++) @(posedge core_clk);
    if (m_done !== 1'b1) check("bus done", 32'h0, 32'h1);
    check("hresp", {31'h0, hresp}, 32'h0);
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d, input ppl_src_e s = SRC_PANEL);
    bus(a, 1'b1, d, s);
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] e, input ppl_src_e s = SRC_PANEL);
    bus(a, 1'b0, e, s);
  endtask
  task automatic pulses(input logic [4:0] e);
    repeat (2) @(posedge core_clk);
    check("pulses", {27'h0, seen}, {27'h0, e});
  endtask
  // parameter access: grant in cycle, refusal pulse one cycle later
  task automatic acc(input logic w, input logic intl, input ppl_src_e s, input logic exp);
    @(posedge core_clk);
    acc_req <= '{vld: 1'b1, wr: w, internal: intl, in_group: 1'b0, src: s};
    seen_clr <= 1'b1;
    @(posedge core_clk);
    seen_clr <= 1'b0;
    #1 check("grant", {31'h0, acc_grant}, {31'h0, exp});
    @(posedge core_clk);
    acc_req <= '0;
    pulses({4'h0, ~exp});
  endtask
  // ==========================================================
  // monitor: oldest note against each completed read
  always @(posedge core_clk) begin
    if (m_done === 1'b1 && hwrite === 1'b0) begin
      mon_e = q.pop_front();
      check($sformatf("read %h", mon_e[36:32]), m_rd, mon_e[31:0]);
    end
  end
  initial begin
    #200000;
    err_count++;
    end_sim();
  end
  // ==========================================================
  // main sequence
  initial begin
    rst_n = 1'b0;
    go = 1'b0;
    m_wr = 1'b0;
    m_addr = 5'h0;
    m_wd = 32'h0;
    seen_clr = 1'b1;
    grs = 1'b0;
    drive_run = 1'b0;
    acc_req = '0;
    bus_src = SRC_PANEL;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(OFF_LEVEL, 32'h270f);
    rd(OFF_PWD, 32'h270f);
    wr(OFF_MASK, 32'h12);
    rd(OFF_MASK, 32'h12);
    wr(OFF_PWD, 32'h4d2);
    pulses(5'h0);
    check("irq", {31'h0, irq}, 32'h1);
    rd(OFF_STAT, 32'h10);
    #1 check("irq", {31'h0, irq}, 32'h0);
    rd(5'h1c, 32'h0);
    rd(OFF_STATE, 32'h0);
    wr(OFF_CMD, 32'h4);
    pulses(5'h10);
    for (i = 0; i < 8; i++) begin
      r = $random(seed);
      acc(r[0], r[3], ppl_src_e'(r[2:1] % 2'h3), 1'b1);
    end
    $display("test open done");
    wr(OFF_LEVEL, 32'h64);
    wr(OFF_PWD, 32'h4d2);
    rd(OFF_STATE, 32'h1);
    rd(OFF_PWD, 32'h0);
    acc(1'b1, 1'b0, SRC_PANEL, 1'b0);
    acc(1'b0, 1'b0, SRC_OPTION, 1'b0);
    acc(1'b1, 1'b1, SRC_PANEL, 1'b1);
    wr(OFF_LEVEL, 32'h4);
    rd(OFF_LEVEL, 32'h64);
    wr(OFF_CMD, 32'h4);
    pulses(5'h0);
    wr(OFF_CMD, 32'h1, SRC_SERIAL);
    pulses(5'h0);
    for (i = 0; i < 4; i++) begin
      wr(OFF_PWD, 32'h7d0);
      pulses(5'h02);
    end
    rd(OFF_PWD, 32'h4);
    wr(OFF_PWD, 32'h4d2);
    rd(OFF_STATE, 32'h12); // unlock keeps the failure count
    acc(1'b1, 1'b0, SRC_PANEL, 1'b1);
    wr(OFF_CMD, 32'h2);
    pulses(5'h08);
    $display("test limited done");
    wr(OFF_LEVEL, 32'hc7);
    wr(OFF_PWD, 32'h15b3);
    for (i = 0; i < 5; i++) wr(OFF_PWD, 32'h7d0);
    rd(OFF_STATE, 32'h17);
    rd(OFF_PWD, 32'h5);
    rd(OFF_STAT, 32'h3f);
    wr(OFF_PWD, 32'h15b3);
    rd(OFF_STATE, 32'h17);
    rd(OFF_STAT, 32'h0);
    drive_run <= 1'b1;
    wr(OFF_CMD, 32'h2);
    pulses(5'h0);
    drive_run <= 1'b0;
    wr(OFF_CMD, 32'h2, SRC_SERIAL);
    pulses(5'h08);
    rd(OFF_STATE, 32'h0);
    rd(OFF_LEVEL, 32'h270f);
    $display("test lockup done");
    wr(OFF_LEVEL, 32'h4);
    wr(OFF_PWD, 32'h4d2);
    wr(OFF_PWD, 32'h7d0);
    pulses(5'h02);
    rd(OFF_PWD, 32'h0);
    acc(1'b1, 1'b0, SRC_PANEL, 1'b0);
    acc(1'b0, 1'b0, SRC_OPTION, 1'b1);
    grs <= 1'b1;
    rd(OFF_LEVEL, 32'h4, SRC_SERIAL);
    rd(OFF_LEVEL, 32'h0);
    grs <= 1'b0;
    wr(OFF_CMD, 32'h1, SRC_OPTION);
    pulses(5'h04);
    rd(OFF_STATE, 32'h0);
    $display("test unlimited done");
    repeat (4) @(posedge core_clk);
    end_sim();
  end
endmodule
